// file: src/radio_seq_map.svh
/*
 * Constants for the radio mode sequencer: route codes, tick codes and
 * timing counts. Assumes core_clk runs at the rate given below.
 */
`ifndef RADIO_SEQ_MAP_SVH
`define RADIO_SEQ_MAP_SVH

// ===
// Timing
`define SEQ_CLK_MHZ 20
`define SEQ_STEP_US 64
`define SEQ_STEP_CYC (`SEQ_STEP_US * `SEQ_CLK_MHZ)
// Each coarser step is 64 of the finer one: 4.1 ms and 262 ms
`define SEQ_STEP_RATIO 64

// ===
// Timer tick field codes
`define TICK_OFF 2'h0
`define TICK_FINE 2'h1
`define TICK_MID 2'h2
`define TICK_COARSE 2'h3

// ===
// Start routes
`define START_LPSEL 2'h0
`define START_RX 2'h1
`define START_TX 2'h2
`define START_TX_LEVEL 2'h3

// ===
// Receive exit routes
`define RXR_PKT_PAYLOAD 3'h1
`define RXR_LP_PAYLOAD 3'h2
`define RXR_PKT_CHECK 3'h3
`define RXR_OFF_LEVEL 3'h4
`define RXR_OFF_SYNC 3'h5
`define RXR_OFF_PREAMBLE 3'h6

// ===
// Timeout routes
`define TOR_RELAUNCH 2'h0
`define TOR_TX 2'h1
`define TOR_LPSEL 2'h2
`define TOR_OFF 2'h3

// ===
// Packet-done routes
`define PDR_OFF 3'h0
`define PDR_TX_EMPTY 3'h1
`define PDR_LPSEL 3'h2
`define PDR_RX_SYNTH 3'h3
`define PDR_RX 3'h4

`endif

// file: src/radio_seq_pkg.sv
/*
 * Types for the radio mode sequencer.
 * Assumes the constants header is included by the design files.
 */
package radio_seq_pkg;
	// Sequencer states, transitory ones included
	typedef enum logic [3:0] {
		ST_OFF, ST_IDLE, ST_TX, ST_RX, ST_PKT, ST_LPSEL, ST_RXTO, ST_WAITQ, ST_SYNTH
	} seq_state_t;
	// Chip mode requested of the transceiver mode controller
	typedef enum logic [2:0] {
		MODE_SLEEP, MODE_STANDBY, MODE_SYNTH, MODE_TX, MODE_RX
	} chip_mode_t;
endpackage

// file: src/tick_bus_if.sv
/*
 * Carries the three step strobes from the prescaler to the timers.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface tick_bus_if;
	logic [2:0] strobe; // One-cycle strobes: 64 us, 4.1 ms, 262 ms
	modport src (output strobe);
	modport dst (input strobe);
endinterface
`default_nettype wire

// file: src/seq_tick_prescaler.sv
/*
 * Divides core_clk into the three timer step strobes.
 * Assumes restart is a one-cycle pulse on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "radio_seq_map.svh"
module seq_tick_prescaler (
	input wire logic core_clk, // System clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic restart, // Realign all steps
	tick_bus_if.src ticks // Step strobes out
);
	localparam int STEP_CYC = `SEQ_STEP_CYC;
	localparam int RATIO = `SEQ_STEP_RATIO;
	logic [10:0] baseCnt_q;
	logic [5:0] midCnt_q;
	logic [5:0] coarseCnt_q;
	logic [2:0] strobe_q;
	logic baseWrap;
	logic midWrap;
	logic coarseWrap;

	if (STEP_CYC > 2048 || RATIO != 64) begin
		$error("prescaler widths cannot serve the step");
	end

	// ===
	// Cascade: one source so all steps are exact multiples
	assign baseWrap = (baseCnt_q == 11'(STEP_CYC - 1)); // R19
	assign midWrap = baseWrap && (midCnt_q == 6'(RATIO - 1));
	assign coarseWrap = midWrap && (coarseCnt_q == 6'(RATIO - 1));

	// Base counter
	always_ff @(posedge core_clk) begin
		if (srst || restart || baseWrap) begin
			baseCnt_q <= 11'h000;
		end else begin
			baseCnt_q <= baseCnt_q + 11'h001;
		end
	end

	// Middle and coarse counters
	always_ff @(posedge core_clk) begin
		if (srst || restart) begin
			midCnt_q <= 6'h00;
			coarseCnt_q <= 6'h00;
		end else begin
			if (baseWrap) midCnt_q <= midCnt_q + 6'h01;
			if (midWrap) coarseCnt_q <= coarseCnt_q + 6'h01;
		end
	end

	// Registered strobes
	always_ff @(posedge core_clk) begin
		if (srst || restart) begin
			strobe_q <= 3'h0;
		end else begin
			strobe_q <= {coarseWrap, midWrap, baseWrap};
		end
	end
	assign ticks.strobe = strobe_q;
endmodule
`default_nettype wire

// file: src/seq_step_timer.sv
/*
 * One sequencer timer: counts a number of selected steps after arm.
 * Assumes arm and cancel are one-cycle pulses on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "radio_seq_map.svh"
module seq_step_timer #(
	parameter int MULT_W = 8 // Multiplier width
) (
	input wire logic core_clk, // System clock
	input wire logic srst, // Synchronous reset, active high
	tick_bus_if.dst ticks, // Step strobes in
	input wire logic [1:0] tickSel, // Step length code
	input wire logic [MULT_W-1:0] multiplier, // Steps to count
	input wire logic arm, // Start counting
	input wire logic cancel, // Abandon counting
	output logic fire // One-cycle expiry pulse
);
	logic [MULT_W-1:0] left_q;
	logic running_q;
	logic fire_q;
	logic step;

	if (MULT_W < 1 || MULT_W > 16) begin
		$error("multiplier width out of range");
	end

	// ===
	// Step selection; code zero never steps
	always_comb begin
		case (tickSel)
			`TICK_FINE: step = ticks.strobe[0]; // R14
			`TICK_MID: step = ticks.strobe[1]; // R14
			`TICK_COARSE: step = ticks.strobe[2]; // R14
			default: step = 1'b0; // R14
		endcase
	end

	// Countdown; multiplier zero expires on the first step like one
	always_ff @(posedge core_clk) begin
		if (srst || cancel) begin
			running_q <= 1'b0;
			left_q <= '0;
		end else if (arm) begin
			running_q <= (tickSel != `TICK_OFF);
			left_q <= multiplier;
		end else if (running_q && step) begin
			left_q <= left_q - MULT_W'(1);
			if (left_q <= MULT_W'(1)) running_q <= 1'b0;
		end
	end

	// Expiry pulse
	always_ff @(posedge core_clk) begin
		if (srst || cancel) begin
			fire_q <= 1'b0;
		end else begin
			fire_q <= running_q && step && !arm && (left_q <= MULT_W'(1));
		end
	end
	assign fire = fire_q;
endmodule
`default_nettype wire

// file: src/radio_mode_sequencer.sv
/*
 * Radio mode sequencer: steps the transceiver among its modes from
 * chip events and two chained periodic timers, with no register traffic.
 * Assumes all event inputs are one-cycle pulses synchronous to core_clk,
 * and that the mode controller follows modeReq while seqActive is high.
 */
// Summary of operation
// (R1) Idle holds standby/sleep; timer A exits.
// (R2) Launch from low power picks first step.
// (R3) Low-power selection: off or idle.
// (R4) Transmit done goes low-power or receive.
// (R5) Receive routes on payload or check pass.
// (R6) Failed check payload goes to timeout handling.
// (R7) Receive routes off on level/sync/preamble.
// (R8) Timer B in receive forces low-power selection.
// (R9) Timeout route picks relaunch/tx/low-power/off.
// (R10) Any of three waits counts as timeout.
// (R11) Packet-received routes per packet-done code.
// (R12) Timer A fires after B or launch.
// (R13) Timer B fires after timer A.
// (R14) Tick codes: off, 64us, 4.1ms, 262ms.
// (R15) Timers alternate independent of sequencer state.
// (R16) Stop forces off immediately, any state.
// (R17) Software never sets launch and stop together.
// (R18) Idle reacts only to timer A.
// (R19) Steps from one prescaler; multiplier width parameter.
`timescale 1ns/1ps
`default_nettype none
`include "radio_seq_map.svh"
module radio_mode_sequencer #(
	parameter int MULT_W = 8 // Timer multiplier width
) (
	input wire logic core_clk, // System clock, 20 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic launchBit, // Launch pulse
	input wire logic stopBit, // Stop pulse
	input wire logic chipInSleep, // Chip low-power mode now: 1 sleep
	input wire logic idlePowerChoice, // Idle: 0 standby, 1 sleep
	input wire logic [1:0] startRoute, // First step after launch
	input wire logic lowPowerChoice, // 0 off, 1 idle
	input wire logic idleExitRoute, // 0 transmit, 1 receive
	input wire logic txExitRoute, // 0 low-power, 1 receive
	input wire logic [2:0] rxExitRoute, // Receive exit code
	input wire logic [1:0] timeoutRoute, // Timeout exit code
	input wire logic [2:0] pktDoneRoute, // Packet-done exit code
	input wire logic checkEnable, // Packet check on
	input wire logic autoDiscardBad, // Bad packets dropped silently
	input wire logic [1:0] timerATick, // Timer A step code
	input wire logic [1:0] timerBTick, // Timer B step code
	input wire logic [MULT_W-1:0] timerAMultiplier, // Timer A steps
	input wire logic [MULT_W-1:0] timerBMultiplier, // Timer B steps
	input wire logic txDoneEvent, // Packet sent
	input wire logic rxPayloadEvent, // Payload ready
	input wire logic checkPassEvent, // Check passed
	input wire logic signalLevelEvent, // Signal level seen
	input wire logic syncMatchEvent, // Sync word matched
	input wire logic preambleSeenEvent, // Preamble seen
	input wire logic levelWaitExpiry, // Level wait timed out
	input wire logic preambleWaitExpiry, // Preamble wait timed out
	input wire logic syncWaitExpiry, // Sync wait timed out
	input wire logic queueEmptyEvent, // Queue empty
	input wire logic queueLevelEvent, // Queue over threshold
	input wire logic synthLockEvent, // Synthesizer locked
	output radio_seq_pkg::chip_mode_t modeReq, // Requested chip mode
	output logic seqActive, // Sequencer holds the chip
	output radio_seq_pkg::seq_state_t seqState, // Current state
	output logic rxRelaunch, // Restart receiver pulse
	output logic timerAEvent, // Timer A pulse
	output logic timerBEvent // Timer B pulse
);
	radio_seq_pkg::seq_state_t state_q;
	radio_seq_pkg::seq_state_t state_d;
	radio_seq_pkg::chip_mode_t mode_q;
	radio_seq_pkg::chip_mode_t mode_d;
	logic initSleep_q;
	logic active_q;
	logic relaunch_q;
	logic relaunch_d;
	logic launchTaken;
	logic rxExpiry;
	logic badPacket;
	logic timerAFire;
	logic timerBFire;

	tick_bus_if ticks ();

	if (MULT_W < 1 || MULT_W > 16) begin
		$error("MULT_W out of range");
	end

	// ===
	// Timers
	// Prescaler realigns on launch so the first delay is whole steps
	assign launchTaken = launchBit && !stopBit && (state_q == radio_seq_pkg::ST_OFF);

	seq_tick_prescaler u_prescaler (
		.core_clk(core_clk),
		.srst(srst),
		.restart(launchTaken), // R19
		.ticks(ticks)
	);

	// Timer A runs after launch or after timer B fires
	seq_step_timer #(.MULT_W(MULT_W)) u_timer_a (
		.core_clk(core_clk),
		.srst(srst),
		.ticks(ticks),
		.tickSel(timerATick),
		.multiplier(timerAMultiplier),
		.arm(launchTaken || timerBFire), // R12
		.cancel(stopBit),
		.fire(timerAFire)
	);

	// Timer B follows timer A whatever the state; one off ends the cycling
	seq_step_timer #(.MULT_W(MULT_W)) u_timer_b (
		.core_clk(core_clk),
		.srst(srst),
		.ticks(ticks),
		.tickSel(timerBTick),
		.multiplier(timerBMultiplier),
		.arm(timerAFire), // R13 R15
		.cancel(stopBit),
		.fire(timerBFire)
	);

	// ===
	// Event conditioning
	assign rxExpiry = levelWaitExpiry || preambleWaitExpiry || syncWaitExpiry; // R10
	// A payload with a failed check only matters when it is not dropped
	assign badPacket = rxPayloadEvent && checkEnable && !autoDiscardBad && !checkPassEvent;

	// ===
	// Next state
	// Transitory states last exactly one cycle
	always_comb begin
		state_d = state_q;
		relaunch_d = 1'b0;
		if (stopBit) begin
			state_d = radio_seq_pkg::ST_OFF; // R16
		end else begin
			case (state_q)
				radio_seq_pkg::ST_OFF: begin
					if (launchTaken) begin
						case (startRoute)
							`START_LPSEL: state_d = radio_seq_pkg::ST_LPSEL; // R2
							`START_RX: state_d = radio_seq_pkg::ST_RX; // R2
							`START_TX: state_d = radio_seq_pkg::ST_TX; // R2
							default: state_d = radio_seq_pkg::ST_WAITQ; // R2
						endcase
					end
				end

				radio_seq_pkg::ST_WAITQ: begin
					// Low power until the queue fills
					if (queueLevelEvent) state_d = radio_seq_pkg::ST_TX; // R2
				end

				radio_seq_pkg::ST_LPSEL: begin
					// Decided in one cycle, never stalls
					if (lowPowerChoice) begin
						state_d = radio_seq_pkg::ST_IDLE; // R3
					end else begin
						state_d = radio_seq_pkg::ST_OFF; // R3
					end
				end

				radio_seq_pkg::ST_IDLE: begin
					// Everything but timer A is ignored here
					if (timerAFire) begin // R18
						state_d = idleExitRoute ? radio_seq_pkg::ST_RX : radio_seq_pkg::ST_TX; // R1
					end
				end

				radio_seq_pkg::ST_TX: begin
					// Timers cannot cut a packet short
					if (txDoneEvent) begin
						state_d = txExitRoute ? radio_seq_pkg::ST_RX : radio_seq_pkg::ST_LPSEL; // R4
					end
				end

				radio_seq_pkg::ST_RX: begin
					// Timer B outranks every route, then timeouts, then route events
					if (timerBFire) begin
						state_d = radio_seq_pkg::ST_LPSEL; // R8
					end else if (rxExpiry) begin
						state_d = radio_seq_pkg::ST_RXTO; // R9
					end else begin
						case (rxExitRoute)
							`RXR_PKT_PAYLOAD: begin
								if (rxPayloadEvent) state_d = radio_seq_pkg::ST_PKT; // R5
							end
							`RXR_LP_PAYLOAD: begin
								if (rxPayloadEvent) state_d = radio_seq_pkg::ST_LPSEL; // R5
							end
							`RXR_PKT_CHECK: begin
								if (checkPassEvent) begin
									state_d = radio_seq_pkg::ST_PKT; // R5
								end else if (badPacket) begin
									state_d = radio_seq_pkg::ST_RXTO; // R6 R9
								end
							end
							`RXR_OFF_LEVEL: begin
								if (signalLevelEvent) state_d = radio_seq_pkg::ST_OFF; // R7
							end
							`RXR_OFF_SYNC: begin
								if (syncMatchEvent) state_d = radio_seq_pkg::ST_OFF; // R7
							end
							`RXR_OFF_PREAMBLE: begin
								if (preambleSeenEvent) state_d = radio_seq_pkg::ST_OFF; // R7
							end
							default: state_d = state_q;
						endcase
					end
				end

				radio_seq_pkg::ST_RXTO: begin
					// Serves expiries and failed packets alike
					case (timeoutRoute)
						`TOR_RELAUNCH: begin
							state_d = radio_seq_pkg::ST_RX; // R9
							relaunch_d = 1'b1; // R9
						end
						`TOR_TX: state_d = radio_seq_pkg::ST_TX; // R9
						`TOR_LPSEL: state_d = radio_seq_pkg::ST_LPSEL; // R9
						default: state_d = radio_seq_pkg::ST_OFF; // R9
					endcase
				end

				radio_seq_pkg::ST_PKT: begin
					// Codes 5 to 7 wait for a stop
					case (pktDoneRoute)
						`PDR_OFF: state_d = radio_seq_pkg::ST_OFF; // R11
						`PDR_TX_EMPTY: begin
							if (queueEmptyEvent) state_d = radio_seq_pkg::ST_TX; // R11
						end
						`PDR_LPSEL: state_d = radio_seq_pkg::ST_LPSEL; // R11
						`PDR_RX_SYNTH: state_d = radio_seq_pkg::ST_SYNTH; // R11
						`PDR_RX: state_d = radio_seq_pkg::ST_RX; // R11
						default: state_d = state_q;
					endcase
				end

				radio_seq_pkg::ST_SYNTH: begin
					// Receive only once the new frequency has locked
					if (synthLockEvent) state_d = radio_seq_pkg::ST_RX; // R11
				end

				default: state_d = radio_seq_pkg::ST_OFF;
			endcase
		end
	end

	// ===
	// Requested chip mode
	// Decoded from state_d so the mode moves with the state
	always_comb begin
		case (state_d)
			radio_seq_pkg::ST_IDLE: begin
				mode_d = idlePowerChoice ? radio_seq_pkg::MODE_SLEEP
					: radio_seq_pkg::MODE_STANDBY; // R1 R3
			end

			radio_seq_pkg::ST_TX: mode_d = radio_seq_pkg::MODE_TX;
			radio_seq_pkg::ST_RX: mode_d = radio_seq_pkg::MODE_RX;
			radio_seq_pkg::ST_PKT: mode_d = radio_seq_pkg::MODE_RX;
			radio_seq_pkg::ST_SYNTH: mode_d = radio_seq_pkg::MODE_SYNTH;

			radio_seq_pkg::ST_OFF: begin
				// Leaving through low-power selection hands back the launch mode
				if (state_q == radio_seq_pkg::ST_LPSEL && !stopBit) begin
					mode_d = initSleep_q ? radio_seq_pkg::MODE_SLEEP
						: radio_seq_pkg::MODE_STANDBY; // R3
				end else begin
					mode_d = mode_q;
				end
			end

			radio_seq_pkg::ST_WAITQ: begin
				// Chip stays in its launch mode while waiting
				mode_d = chipInSleep ? radio_seq_pkg::MODE_SLEEP : radio_seq_pkg::MODE_STANDBY;
			end
			default: mode_d = mode_q;
		endcase
	end

	// ===
	// State register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q <= radio_seq_pkg::ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// Mode register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode_q <= radio_seq_pkg::MODE_STANDBY;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Launch mode capture: only a launch from off is honoured
	always_ff @(posedge core_clk) begin
		if (srst) begin
			initSleep_q <= 1'b0;
		end else if (launchTaken) begin
			initSleep_q <= chipInSleep; // R3
		end
	end

	// Ownership flag
	// Taken from state_d so it tracks state_q exactly
	always_ff @(posedge core_clk) begin
		if (srst) begin
			active_q <= 1'b0;
		end else begin
			active_q <= (state_d != radio_seq_pkg::ST_OFF); // R16
		end
	end

	// Receiver relaunch pulse
	always_ff @(posedge core_clk) begin
		if (srst) begin
			relaunch_q <= 1'b0;
		end else begin
			relaunch_q <= relaunch_d; // R9
		end
	end

	// ===
	// Outputs, all from flip-flops
	assign modeReq = mode_q;
	assign seqActive = active_q;
	assign seqState = state_q;
	assign rxRelaunch = relaunch_q;
	assign timerAEvent = timerAFire;
	assign timerBEvent = timerBFire;
endmodule
`default_nettype wire

// file: tb/radio_seq_partner.sv
/*
 * Far-side model: mode controller and packet engine events.
 * Assumes modeReq and seqActive come from the sequencer on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module radio_seq_partner (
	input wire logic core_clk, // Clock
	input wire logic srst, // Reset
	input wire radio_seq_pkg::chip_mode_t modeReq, // Mode asked for
	input wire logic seqActive, // Sequencer owns chip
	input wire logic sleepInit, // Mode set by software
	output logic chipInSleep, // Chip low-power mode
	output logic txDoneEvent, // Packet sent
	output logic synthLockEvent // Synthesizer locked
);
	logic [3:0] dwell_q;
	// Chip follows the request only while the sequencer holds it
	assign chipInSleep = seqActive ? (modeReq == radio_seq_pkg::MODE_SLEEP) : sleepInit;
	// Radio takes a few cycles per mode
	always_ff @(posedge core_clk) begin
		if (srst || !seqActive || modeReq != $past(modeReq)) begin
			dwell_q <= 4'h0;
		end else if (dwell_q != 4'hF) begin
			dwell_q <= dwell_q + 4'h1;
		end
	end
	assign txDoneEvent = seqActive && dwell_q == 4'h4 && modeReq == radio_seq_pkg::MODE_TX;
	assign synthLockEvent = seqActive && dwell_q == 4'h4 && modeReq == radio_seq_pkg::MODE_SYNTH;
endmodule
`default_nettype wire

// file: tb/radio_mode_sequencer_assertions.sv
/*
 * Concurrent checks on the sequencer routing.
 * Assumes it is bound to radio_mode_sequencer and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module radio_mode_sequencer_checker (
	input wire logic core_clk, // Clock
	input wire logic srst, // Reset
	input wire logic stopBit, // Stop pulse
	input wire logic idlePowerChoice, // Idle mode
	input wire logic lowPowerChoice, // Off or idle
	input wire logic txExitRoute, // Transmit exit
	input wire logic [1:0] timeoutRoute, // Timeout exit
	input wire logic txDoneEvent, // Packet sent
	input wire logic levelWaitExpiry, // Wait expiry
	input wire logic preambleWaitExpiry, // Wait expiry
	input wire logic syncWaitExpiry, // Wait expiry
	input wire radio_seq_pkg::chip_mode_t modeReq, // Mode asked
	input wire radio_seq_pkg::seq_state_t seqState, // State
	input wire logic rxRelaunch, // Restart pulse
	input wire logic timerAEvent, // Timer A pulse
	input wire logic timerBEvent // Timer B pulse
);
	// ===
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_stop;
		stopBit |=> seqState == radio_seq_pkg::ST_OFF;
	endproperty
	property p_idle_hold;
		seqState == radio_seq_pkg::ST_IDLE && !timerAEvent && !stopBit
			|=> seqState == radio_seq_pkg::ST_IDLE;
	endproperty
	// Mode is looked at once idle has settled, so a late choice change is excused
	property p_idle_mode;
		seqState == radio_seq_pkg::ST_IDLE && $past(seqState) == radio_seq_pkg::ST_IDLE
			&& $stable(idlePowerChoice) |-> modeReq == (idlePowerChoice ?
			radio_seq_pkg::MODE_SLEEP : radio_seq_pkg::MODE_STANDBY);
	endproperty
	property p_tx_done;
		seqState == radio_seq_pkg::ST_TX && txDoneEvent && !stopBit |=> seqState ==
			(txExitRoute ? radio_seq_pkg::ST_RX : radio_seq_pkg::ST_LPSEL);
	endproperty
	property p_lpsel;
		seqState == radio_seq_pkg::ST_LPSEL && !stopBit |=> seqState ==
			(lowPowerChoice ? radio_seq_pkg::ST_IDLE : radio_seq_pkg::ST_OFF);
	endproperty
	property p_relaunch;
		seqState == radio_seq_pkg::ST_RXTO && !stopBit && timeoutRoute == 2'h0
			|=> seqState == radio_seq_pkg::ST_RX && rxRelaunch ##1 !rxRelaunch;
	endproperty
	property p_expiry;
		seqState == radio_seq_pkg::ST_RX && !stopBit && !timerBEvent && (levelWaitExpiry
			|| preambleWaitExpiry || syncWaitExpiry) |=> seqState == radio_seq_pkg::ST_RXTO;
	endproperty
	property p_timer_b_rx;
		seqState == radio_seq_pkg::ST_RX && timerBEvent && !stopBit
			|=> seqState == radio_seq_pkg::ST_LPSEL;
	endproperty
	// ===
	// Assertions and covers
	a_stop: assert property (p_stop) else $error("stop did not force off");
	a_idle_hold: assert property (p_idle_hold) else $error("idle left early");
	a_idle_mode: assert property (p_idle_mode) else $error("idle mode wrong");
	a_tx_done: assert property (p_tx_done) else $error("transmit exit wrong");
	a_lpsel: assert property (p_lpsel) else $error("low-power pick wrong");
	a_relaunch: assert property (p_relaunch) else $error("relaunch wrong");
	a_expiry: assert property (p_expiry) else $error("expiry not routed");
	a_timer_b_rx: assert property (p_timer_b_rx) else $error("timer B ignored");
	c_relaunch: cover property (rxRelaunch);
	c_idle_rx: cover property (seqState == radio_seq_pkg::ST_IDLE ##1 seqState == radio_seq_pkg::ST_RX);
	c_timer_b: cover property (timerBEvent);
endmodule
bind radio_mode_sequencer radio_mode_sequencer_checker radio_mode_sequencer_checker_i (
	.core_clk(core_clk), .srst(srst), .stopBit(stopBit), .idlePowerChoice(idlePowerChoice),
	.lowPowerChoice(lowPowerChoice), .txExitRoute(txExitRoute), .timeoutRoute(timeoutRoute),
	.txDoneEvent(txDoneEvent), .levelWaitExpiry(levelWaitExpiry),
	.preambleWaitExpiry(preambleWaitExpiry), .syncWaitExpiry(syncWaitExpiry),
	.modeReq(modeReq), .seqState(seqState), .rxRelaunch(rxRelaunch),
	.timerAEvent(timerAEvent), .timerBEvent(timerBEvent));
`default_nettype wire

// file: tb/radio_mode_sequencer_bench.sv
/*
 * Self-checking bench: launches, routes, timers and stop.
 * Assumes the map header is on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "radio_seq_map.svh"
module radio_mode_sequencer_bench;
	logic core_clk = 1'h0, srst = 1'h1, launchBit = 1'h0, stopBit = 1'h0, sleepInit = 1'h1;
	logic idlePowerChoice = 1'h0, lowPowerChoice = 1'h0, idleExitRoute = 1'h1;
	logic txExitRoute = 1'h0, checkEnable = 1'h1, autoDiscardBad = 1'h0;
	logic [1:0] startRoute = 2'h0, timeoutRoute = 2'h0, timerATick = 2'h1, timerBTick = 2'h1;
	logic [2:0] rxExitRoute = 3'h0, pktDoneRoute = 3'h0;
	logic [7:0] timerAMultiplier = 8'h02, timerBMultiplier = 8'h01;
	logic [9:0] ev = 10'h000; // Event pulses, one bit each
	wire chipInSleep, txDoneEvent, synthLockEvent, seqActive, rxRelaunch, timerAEvent, timerBEvent;
	radio_seq_pkg::chip_mode_t modeReq;
	radio_seq_pkg::seq_state_t seqState;
	radio_seq_pkg::seq_state_t tbl[5];
	int error_cnt = 0, cmp_count = 0, cyc = 0, nb = 0, t0, t1;
	// ===
	// Clock, cycle count and timer B tally
	initial forever #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (timerBEvent === 1'h1) nb <= nb + 1;
	end
	radio_mode_sequencer radio_mode_sequencer_i (.core_clk(core_clk), .srst(srst),
		.launchBit(launchBit), .stopBit(stopBit), .chipInSleep(chipInSleep),
		.idlePowerChoice(idlePowerChoice), .startRoute(startRoute), .lowPowerChoice(lowPowerChoice),
		.idleExitRoute(idleExitRoute), .txExitRoute(txExitRoute), .rxExitRoute(rxExitRoute),
		.timeoutRoute(timeoutRoute), .pktDoneRoute(pktDoneRoute), .checkEnable(checkEnable),
		.autoDiscardBad(autoDiscardBad), .timerATick(timerATick), .timerBTick(timerBTick),
		.timerAMultiplier(timerAMultiplier), .timerBMultiplier(timerBMultiplier),
		.txDoneEvent(txDoneEvent), .rxPayloadEvent(ev[0]), .checkPassEvent(ev[1]),
		.signalLevelEvent(ev[2]), .syncMatchEvent(ev[3]), .preambleSeenEvent(ev[4]),
		.levelWaitExpiry(ev[5]), .preambleWaitExpiry(ev[6]), .syncWaitExpiry(ev[7]),
		.queueEmptyEvent(ev[8]), .queueLevelEvent(ev[9]), .synthLockEvent(synthLockEvent),
		.modeReq(modeReq), .seqActive(seqActive), .seqState(seqState), .rxRelaunch(rxRelaunch),
		.timerAEvent(timerAEvent), .timerBEvent(timerBEvent));
	radio_seq_partner radio_seq_partner_i (.core_clk(core_clk), .srst(srst), .modeReq(modeReq),
		.seqActive(seqActive), .sleepInit(sleepInit), .chipInSleep(chipInSleep),
		.txDoneEvent(txDoneEvent), .synthLockEvent(synthLockEvent));
	// ===
	// Access tasks: inputs move 2 ns after each rising edge
	task automatic step(); @(posedge core_clk); #2; endtask
	task automatic bad(input string m);
		error_cnt++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic cmpSt(input radio_seq_pkg::seq_state_t e);
		cmp_count++;
		if (seqState !== e || seqActive !== (e != radio_seq_pkg::ST_OFF))
			bad($sformatf("state %0d, want %0d", seqState, e));
	endtask
	task automatic cmpMd(input radio_seq_pkg::chip_mode_t e);
		cmp_count++;
		if (modeReq !== e) bad("mode request wrong");
	endtask
	task automatic cmpN(input int n, input int lo, input int hi);
		cmp_count++;
		if (n < lo || n > hi) bad($sformatf("count %0d outside %0d..%0d", n, lo, hi));
	endtask
	// Launch never overlaps stop; if both are set the sequencer lets stop win
	task automatic launch(input int r);
		step(); startRoute = r[1:0]; launchBit = 1'h1;
		step(); launchBit = 1'h0;
	endtask
	task automatic stop(); step(); stopBit = 1'h1; step(); stopBit = 1'h0; cmpSt(radio_seq_pkg::ST_OFF); endtask
	task automatic pulse(input int k); step(); ev[k] = 1'h1; step(); ev[k] = 1'h0; endtask
	task automatic waitSt(input radio_seq_pkg::seq_state_t e);
		int n = 0;
		while (seqState !== e && n < 3000) begin step(); n++; end
		cmpSt(e);
	endtask
	// Bounded wait for a timer pulse; returns the cycle it was seen
	task automatic waitT(input bit b, output int t);
		int n = 0;
		while ((b ? timerBEvent : timerAEvent) !== 1'h1 && n < 4000) begin step(); n++; end
		t = cyc;
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ===
	// Watchdog: all tests take under 20000 cycles
	initial begin
		repeat (60000) @(posedge core_clk);
		bad("watchdog");
		summarize();
	end
	// ===
	// Tests
	initial begin
		repeat (12) step();
		srst = 1'h0;
		cmpSt(radio_seq_pkg::ST_OFF); cmpMd(radio_seq_pkg::MODE_STANDBY);
		$display("test reset done");
		tbl = '{radio_seq_pkg::ST_LPSEL, radio_seq_pkg::ST_RX, radio_seq_pkg::ST_TX,
			radio_seq_pkg::ST_WAITQ, radio_seq_pkg::ST_OFF};
		for (int r = 0; r < 4; r++) begin
			launch(r); cmpSt(tbl[r]);
			if (r == 0) begin step(); cmpSt(radio_seq_pkg::ST_OFF); cmpMd(radio_seq_pkg::MODE_SLEEP); end
			if (r == 3) begin pulse(9); cmpSt(radio_seq_pkg::ST_TX); end
			stop();
		end
		sleepInit = 1'h0; txExitRoute = 1'h1;
		launch(2); waitSt(radio_seq_pkg::ST_RX); stop();
		$display("test start routes done");
		for (int k = 0; k < 3; k++) begin
			rxExitRoute = 3'h4 + k[2:0]; launch(1);
			pulse(2 + (k + 1) % 3); cmpSt(radio_seq_pkg::ST_RX);
			pulse(2 + k); cmpSt(radio_seq_pkg::ST_OFF);
		end
		lowPowerChoice = 1'h1; rxExitRoute = 3'h1;
		tbl = '{radio_seq_pkg::ST_OFF, radio_seq_pkg::ST_TX, radio_seq_pkg::ST_IDLE,
			radio_seq_pkg::ST_RX, radio_seq_pkg::ST_RX};
		for (int p = 0; p < 5; p++) begin
			pktDoneRoute = p[2:0]; launch(1); pulse(0);
			if (p == 1) begin cmpSt(radio_seq_pkg::ST_PKT); pulse(8); end
			waitSt(tbl[p]); stop();
		end
		rxExitRoute = 3'h2; launch(1); pulse(0); waitSt(radio_seq_pkg::ST_IDLE);
		cmpMd(radio_seq_pkg::MODE_STANDBY); stop();
		rxExitRoute = 3'h3; lowPowerChoice = 1'h0;
		launch(1); pulse(1); cmpSt(radio_seq_pkg::ST_PKT); stop();
		$display("test receive routes done");
		tbl = '{radio_seq_pkg::ST_RX, radio_seq_pkg::ST_TX, radio_seq_pkg::ST_OFF,
			radio_seq_pkg::ST_OFF, radio_seq_pkg::ST_OFF};
		for (int t = 0; t < 4; t++) begin
			timeoutRoute = t[1:0]; launch(1); pulse(0); cmpSt(radio_seq_pkg::ST_RXTO);
			waitSt(tbl[t]); stop();
		end
		rxExitRoute = 3'h0;
		for (int k = 5; k < 8; k++) begin
			launch(1); pulse(k); cmpSt(radio_seq_pkg::ST_RXTO); waitSt(radio_seq_pkg::ST_OFF);
		end
		$display("test timeout routes done");
		idlePowerChoice = 1'h1; lowPowerChoice = 1'h1;
		launch(0); t0 = cyc; step(); cmpSt(radio_seq_pkg::ST_IDLE); cmpMd(radio_seq_pkg::MODE_SLEEP);
		for (int k = 0; k < 10; k++) pulse(k);
		cmpSt(radio_seq_pkg::ST_IDLE);
		waitT(0, t1); cmpN(t1 - t0, 2560, 2565);
		step(); cmpSt(radio_seq_pkg::ST_RX);
		waitT(1, t0); cmpN(t0 - t1, 1275, 1285);
		waitSt(radio_seq_pkg::ST_IDLE);
		waitT(0, t1); cmpN(t1 - t0, 2555, 2565);
		timerBTick = `TICK_OFF; t0 = nb;
		repeat (1500) step();
		cmpN(nb - t0, 0, 0); cmpSt(radio_seq_pkg::ST_RX); stop();
		$display("test timers done");
		summarize();
	end
endmodule
`default_nettype wire
